//--- verilog/flpd_cfg.svh
// Offsets, field positions, reset values and memory word geometry of the field loader
`ifndef FLPD_CFG_SVH
`define FLPD_CFG_SVH

// APB byte offsets
`define FLPD_OFF_CFG        12'h000
`define FLPD_OFF_INSTR      12'h004
`define FLPD_OFF_STATUS     12'h008
`define FLPD_OFF_REG_IDX    12'h00c
`define FLPD_OFF_REG_DATA   12'h010

// Field configuration register layout
`define FLPD_CFG_SIZE_A_LSB 0
`define FLPD_CFG_EXT_A_BIT  5
`define FLPD_CFG_SIZE_B_LSB 8
`define FLPD_CFG_EXT_B_BIT  13
`define FLPD_CFG_RESET      32'h0000_0000

// Instruction word layout
`define FLPD_INS_SEL_BIT    9
`define FLPD_INS_SRC_LSB    5
`define FLPD_INS_FILE_BIT   4
`define FLPD_INS_DST_LSB    0

// Status register layout
`define FLPD_ST_BUSY_BIT    0
`define FLPD_ST_V_BIT       4
`define FLPD_ST_Z_BIT       5
`define FLPD_ST_C_BIT       6
`define FLPD_ST_N_BIT       7

// Memory word geometry, bits per word and words in the window
`define FLPD_WORD_BITS      16
`define FLPD_WINDOW_WORDS   3
`define FLPD_FIELD_MAX      32

`endif

//--- verilog/flpd_pkg.sv
// Types shared by the field loader modules
package flpd_pkg;

    typedef struct packed {
        logic       ext;
        logic [4:0] size;
    } flpd_field_cfg_s;

    typedef struct packed {
        logic [5:0] opcode;
        logic       size_select;
        logic [3:0] source_pointer_reg;
        logic       file_select;
        logic [3:0] dest_reg;
    } flpd_instr_s;

    typedef struct packed {
        logic n;
        logic c;
        logic z;
        logic v;
    } flpd_flags_s;

    typedef enum logic [2:0] {
        FLPD_IDLE,
        FLPD_DEC,
        FLPD_READ,
        FLPD_GAP,
        FLPD_EXT,
        FLPD_DONE
    } flpd_state_e;

endpackage : flpd_pkg

//--- verilog/flpd_field_extract.sv
// Right-justifies a field out of the fetched word window and extends it
`timescale 1ns/10ps
`include "flpd_cfg.svh"

module flpd_field_extract
    import flpd_pkg::*;
#(
    parameter int WIN_BITS = `FLPD_WORD_BITS * `FLPD_WINDOW_WORDS
) (
    input  wire logic [WIN_BITS-1:0] i_window,
    input  wire logic [3:0]          i_offset,
    input  wire logic [5:0]          i_width,
    input  wire logic                i_sign_ext,
    output logic      [31:0]         o_value,
    output logic                     o_negative,
    output logic                     o_zero
);

    logic [WIN_BITS-1:0] shifted;
    logic                top_bit;

    always_comb begin
        shifted = i_window >> i_offset;
        top_bit = shifted[i_width[4:0] - 5'd1];
        if (i_width == 6'd32) begin
            top_bit = shifted[31];
        end
    end

    // Bits above the width take the sign or zero
    for (genvar i = 0; i < 32; i++) begin : g_bit
        always_comb begin
            if (i < i_width) begin
                o_value[i] = shifted[i];
            end else begin
                o_value[i] = i_sign_ext & top_bit;
            end
        end
    end

    // Compare with zero on the extended value
    always_comb begin
        o_negative = o_value[31];
        o_zero     = (o_value == 32'h0000_0000);
    end

endmodule : flpd_field_extract

//--- verilog/flpd_top.sv
// Field load with predecremented pointer: APB registers, register file, datapath
//
// Function
// (RL1) The pointer is reduced by the selected field size and that value is the field's bit address.
// (RL2) The reduced pointer stays in the pointer register with no later adjustment.
// (RL3) Field widths of one to thirty-two bits come from the selected size setting.
// (RL4) A clear select bit picks size_setting_a and its extension, a set bit size_setting_b.
// (RL5) The field lands right-justified in the destination, sign or zero extended to 32 bits.
// (RL6) Sign or zero extension follows the extension_select of the chosen setting.
// (RL7) The extended value is compared with zero and the flags follow from it.
// (RL8) Software names pointer and destination in the same register file.
// (RL9) When pointer and destination coincide, the fetched data replaces the pointer.
// (RL10) An aligned 16-bit field takes 4 states and a 32-bit one 6, plus memory waits.
// (RL11) N follows the sign, Z is set on zero, C is kept and V is cleared.
// (RL12) A field crossing a 16-bit word boundary is built from consecutive word reads.
// (RL13) Instruction bit 9 selects the setting, then pointer, file bit and destination.
`timescale 1ns/10ps
`include "flpd_cfg.svh"

module flpd_top
    import flpd_pkg::*;
#(
    parameter int REGS_PER_FILE = 16
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_mem_req,
    output logic      [27:0] o_mem_word_addr,
    input  wire logic        i_mem_ack,
    input  wire logic [15:0] i_mem_rdata,
    output logic             o_busy
);

    localparam int WIN_BITS = `FLPD_WORD_BITS * `FLPD_WINDOW_WORDS;
    localparam int IDX_BITS = $clog2(2 * REGS_PER_FILE);

    // Register file: both files in one array, file bit on top
    logic [31:0] gp_regs [2 * REGS_PER_FILE];

    // State
    flpd_state_e         state;
    flpd_field_cfg_s     size_setting_a;
    flpd_field_cfg_s     size_setting_b;
    flpd_instr_s         instr;
    flpd_flags_s         flags;
    logic [31:0]         field_addr;
    logic [5:0]          width;
    logic                extension_select;
    logic [1:0]          words_left;
    logic [1:0]          word_slot;
    logic [WIN_BITS-1:0] window;
    logic [IDX_BITS-1:0] reg_idx;

    flpd_state_e         next_state;
    flpd_field_cfg_s     next_size_setting_a;
    flpd_field_cfg_s     next_size_setting_b;
    flpd_instr_s         next_instr;
    flpd_flags_s         next_flags;
    logic [31:0]         next_field_addr;
    logic [5:0]          next_width;
    logic                next_extension_select;
    logic [1:0]          next_words_left;
    logic [1:0]          next_word_slot;
    logic [WIN_BITS-1:0] next_window;
    logic [IDX_BITS-1:0] next_reg_idx;
    logic                next_mem_req;
    logic [27:0]         next_mem_word_addr;
    logic                next_busy;
    logic [31:0]         next_prdata;
    logic                next_pready;
    logic                next_pslverr;

    // Register file write port
    logic                rf_we;
    logic [IDX_BITS-1:0] rf_waddr;
    logic [31:0]         rf_wdata;

    // Datapath helpers
    logic                setup_phase;
    logic                bus_write;
    logic                addr_known;
    logic [IDX_BITS-1:0] src_idx;
    logic [IDX_BITS-1:0] dst_idx;
    flpd_field_cfg_s     sel_cfg;
    logic [5:0]          sel_width;
    logic [31:0]         dec_ptr;
    logic [5:0]          span_bits;
    logic [31:0]         ext_value;
    logic                ext_negative;
    logic                ext_zero;

    flpd_field_extract #(
        .WIN_BITS (WIN_BITS)
    ) u_extract (
        .i_window   (window),
        .i_offset   (field_addr[3:0]),
        .i_width    (width),
        .i_sign_ext (extension_select),
        .o_value    (ext_value),
        .o_negative (ext_negative),
        .o_zero     (ext_zero)
    );

    // Decode of the issued instruction and its field setting
    always_comb begin
        src_idx   = IDX_BITS'({instr.file_select, instr.source_pointer_reg}); // [RL8] [RL13]
        dst_idx   = IDX_BITS'({instr.file_select, instr.dest_reg});           // [RL8] [RL13]
        sel_cfg   = instr.size_select ? size_setting_b : size_setting_a;      // [RL4]
        // Size code zero stands for a full 32-bit field
        sel_width = (sel_cfg.size == 5'd0) ? 6'd32 : {1'b0, sel_cfg.size};    // [RL3]
        dec_ptr   = gp_regs[src_idx] - {26'h0, sel_width};                    // [RL1]
        span_bits = {2'b00, dec_ptr[3:0]} + sel_width - 6'd1;
    end

    // Bus decode
    always_comb begin
        setup_phase = i_psel & ~i_penable & ~o_pready;
        bus_write   = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
        unique case (i_paddr)
            `FLPD_OFF_CFG,
            `FLPD_OFF_INSTR,
            `FLPD_OFF_STATUS,
            `FLPD_OFF_REG_IDX,
            `FLPD_OFF_REG_DATA: addr_known = 1'b1;
            default:            addr_known = 1'b0;
        endcase
    end

    // APB slave: one wait-free access phase after each setup
    always_comb begin
        next_pready  = setup_phase;
        next_pslverr = 1'b0;
        next_prdata  = 32'h0000_0000;
        if (setup_phase) begin
            // Instruction issue and register data access are refused while busy
            next_pslverr = ~addr_known |
                           (o_busy & i_pwrite & (i_paddr == `FLPD_OFF_INSTR)) |
                           (o_busy & (i_paddr == `FLPD_OFF_REG_DATA));
            if (!i_pwrite) begin
                unique case (i_paddr)
                    `FLPD_OFF_CFG: begin
                        next_prdata[`FLPD_CFG_SIZE_A_LSB +: 5] = size_setting_a.size;
                        next_prdata[`FLPD_CFG_EXT_A_BIT]       = size_setting_a.ext;
                        next_prdata[`FLPD_CFG_SIZE_B_LSB +: 5] = size_setting_b.size;
                        next_prdata[`FLPD_CFG_EXT_B_BIT]       = size_setting_b.ext;
                    end
                    `FLPD_OFF_INSTR:    next_prdata[15:0] = instr;
                    `FLPD_OFF_STATUS: begin
                        next_prdata[`FLPD_ST_BUSY_BIT] = o_busy;
                        next_prdata[`FLPD_ST_N_BIT]    = flags.n;
                        next_prdata[`FLPD_ST_C_BIT]    = flags.c;
                        next_prdata[`FLPD_ST_Z_BIT]    = flags.z;
                        next_prdata[`FLPD_ST_V_BIT]    = flags.v;
                    end
                    `FLPD_OFF_REG_IDX:  next_prdata[IDX_BITS-1:0] = reg_idx;
                    `FLPD_OFF_REG_DATA: next_prdata = o_busy ? 32'h0000_0000 : gp_regs[reg_idx];
                    default:            next_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // Sequencer and datapath
    always_comb begin
        next_state            = state;
        next_size_setting_a   = size_setting_a;
        next_size_setting_b   = size_setting_b;
        next_instr            = instr;
        next_flags            = flags;
        next_field_addr       = field_addr;
        next_width            = width;
        next_extension_select = extension_select;
        next_words_left       = words_left;
        next_word_slot        = word_slot;
        next_window           = window;
        next_reg_idx          = reg_idx;
        next_mem_word_addr    = o_mem_word_addr;
        rf_we                 = 1'b0;
        rf_waddr              = dst_idx;
        rf_wdata              = ext_value;

        if (bus_write) begin
            unique case (i_paddr)
                `FLPD_OFF_CFG: begin
                    next_size_setting_a.size = i_pwdata[`FLPD_CFG_SIZE_A_LSB +: 5];
                    next_size_setting_a.ext  = i_pwdata[`FLPD_CFG_EXT_A_BIT];
                    next_size_setting_b.size = i_pwdata[`FLPD_CFG_SIZE_B_LSB +: 5];
                    next_size_setting_b.ext  = i_pwdata[`FLPD_CFG_EXT_B_BIT];
                end
                `FLPD_OFF_INSTR: begin
                    next_instr = i_pwdata[15:0];
                    next_state = FLPD_DEC;
                end
                `FLPD_OFF_STATUS: begin
                    next_flags.n = i_pwdata[`FLPD_ST_N_BIT];
                    next_flags.c = i_pwdata[`FLPD_ST_C_BIT];
                    next_flags.z = i_pwdata[`FLPD_ST_Z_BIT];
                    next_flags.v = i_pwdata[`FLPD_ST_V_BIT];
                end
                `FLPD_OFF_REG_IDX: next_reg_idx = i_pwdata[IDX_BITS-1:0];
                `FLPD_OFF_REG_DATA: begin
                    rf_we    = 1'b1;
                    rf_waddr = reg_idx;
                    rf_wdata = i_pwdata;
                end
                default: rf_we = 1'b0;
            endcase
        end

        unique case (state)
            FLPD_IDLE: next_word_slot = 2'd0;
            FLPD_DEC: begin
                // Pointer is written back here; only the destination write in FLPD_EXT can replace it later
                rf_we                 = 1'b1;                                // [RL2]
                rf_waddr              = src_idx;                             // [RL2]
                rf_wdata              = dec_ptr;                             // [RL1] [RL2]
                next_field_addr       = dec_ptr;                             // [RL1]
                next_width            = sel_width;                           // [RL3]
                next_extension_select = sel_cfg.ext;                         // [RL6]
                next_words_left       = 2'(span_bits[5:4]);                  // [RL12]
                next_mem_word_addr    = dec_ptr[31:4];
                next_window           = '0;
                next_state            = FLPD_READ;
            end
            FLPD_READ: begin
                if (i_mem_ack) begin
                    // Words are stacked low to high as addresses rise
                    next_window[word_slot * `FLPD_WORD_BITS +: `FLPD_WORD_BITS] =
                        i_mem_rdata;                                         // [RL12]
                    next_word_slot     = word_slot + 2'd1;
                    next_mem_word_addr = o_mem_word_addr + 28'd1;            // [RL12]
                    if (words_left == 2'd0) begin
                        next_state = FLPD_EXT;
                    end else begin
                        next_words_left = words_left - 2'd1;
                        // Gap state keeps the 6-state figure for two words
                        next_state      = FLPD_GAP;                          // [RL10]
                    end
                end
            end
            FLPD_GAP: next_state = FLPD_READ;                                 // [RL10]
            FLPD_EXT: begin
                // Written after the pointer, so data wins on a shared register
                rf_we        = 1'b1;                                         // [RL5] [RL9]
                rf_waddr     = dst_idx;                                      // [RL9]
                rf_wdata     = ext_value;                                    // [RL5]
                next_flags.n = ext_negative;                                 // [RL7] [RL11]
                next_flags.z = ext_zero;                                     // [RL7] [RL11]
                next_flags.v = 1'b0;                                         // [RL11]
                next_state   = FLPD_DONE;
            end
            FLPD_DONE: next_state = FLPD_IDLE;                                // [RL10]
        endcase

        next_mem_req = (next_state == FLPD_READ) &
                       ((state != FLPD_READ) | ~i_mem_ack);
        next_busy    = (next_state != FLPD_IDLE);
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state            <= FLPD_IDLE;
            size_setting_a   <= flpd_field_cfg_s'(`FLPD_CFG_RESET);
            size_setting_b   <= flpd_field_cfg_s'(`FLPD_CFG_RESET);
            instr            <= '0;
            flags            <= '0;
            field_addr       <= 32'h0000_0000;
            width            <= 6'h20;
            extension_select <= 1'b0;
            words_left       <= 2'h0;
            word_slot        <= 2'h0;
            window           <= '0;
            reg_idx          <= '0;
            o_mem_req        <= 1'b0;
            o_mem_word_addr  <= 28'h000_0000;
            o_busy           <= 1'b0;
            o_prdata         <= 32'h0000_0000;
            o_pready         <= 1'b0;
            o_pslverr        <= 1'b0;
        end else begin
            state            <= next_state;
            size_setting_a   <= next_size_setting_a;
            size_setting_b   <= next_size_setting_b;
            instr            <= next_instr;
            flags            <= next_flags;
            field_addr       <= next_field_addr;
            width            <= next_width;
            extension_select <= next_extension_select;
            words_left       <= next_words_left;
            word_slot        <= next_word_slot;
            window           <= next_window;
            reg_idx          <= next_reg_idx;
            o_mem_req        <= next_mem_req;
            o_mem_word_addr  <= next_mem_word_addr;
            o_busy           <= next_busy;
            o_prdata         <= next_prdata;
            o_pready         <= next_pready;
            o_pslverr        <= next_pslverr;
        end
    end

    // Register file has no reset; software loads it before use
    always_ff @(posedge i_core_clk) begin
        if (rf_we) begin
            gp_regs[rf_waddr] <= rf_wdata;
        end
    end

endmodule : flpd_top

//--- verif/flpd_top_sva.sv
// Port-level assertions for the predecrement field loader
`timescale 1ns/10ps
`include "flpd_cfg.svh"

module flpd_top_sva
    import flpd_pkg::*;
#(
    parameter int REGS_PER_FILE = 16
) (
    input wire logic        i_core_clk,
    input wire logic        i_reset_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_mem_req,
    input wire logic [27:0] o_mem_word_addr,
    input wire logic        i_mem_ack,
    input wire logic [15:0] i_mem_rdata,
    input wire logic        o_busy
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);

    a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready one cycle after setup");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");
    a_instr_starts: assert property (i_psel && i_penable && i_pwrite && o_pready && !o_busy
        && !o_pslverr && i_paddr == `FLPD_OFF_INSTR |=> o_busy)
        else $error("accepted instruction did not start");
    a_first_fetch: assert property ($rose(o_busy) |=> o_mem_req)
        else $error("no fetch right after the decrement");
    a_busy_minimum: assert property ($rose(o_busy) |-> o_busy [*4])
        else $error("instruction shorter than four states");
    a_fetch_in_busy: assert property (o_mem_req |-> o_busy)
        else $error("fetch outside an instruction");
    a_fetch_holds: assert property (o_mem_req && !i_mem_ack |=>
        o_mem_req && $stable(o_mem_word_addr))
        else $error("fetch dropped or moved before ack");
    a_next_word: assert property ((o_mem_req && i_mem_ack) ##2 o_mem_req |->
        o_mem_word_addr == $past(o_mem_word_addr, 2) + 28'h1)
        else $error("follow-on word not consecutive");
    a_finish_after_last: assert property ((o_mem_req && i_mem_ack) ##1 !o_mem_req
        ##1 !o_mem_req |=> !o_busy)
        else $error("busy not dropped two states after last word");
endmodule : flpd_top_sva

bind flpd_top flpd_top_sva #(.REGS_PER_FILE(REGS_PER_FILE)) i_flpd_top_sva (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_mem_req(o_mem_req),
    .o_mem_word_addr(o_mem_word_addr), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
    .o_busy(o_busy)
);

//--- verif/flpd_top_tb.sv
// Self-checking bench for the predecrement field loader
`timescale 1ns/10ps
`include "flpd_cfg.svh"

module flpd_top_tb;
    typedef struct {logic rd; logic [31:0] data; logic err;} flpd_exp_s;
    flpd_exp_s   exp_q[$];
    flpd_exp_s   cur;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, busy;
    logic        mem_req, mem_ack, mem_ready, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [27:0] mem_addr;
    logic [15:0] mem_rdata, salt;
    int          bad_count = 0, tests_run = 0, busy_cnt = 0, wait_cnt = 0;

    function automatic logic [15:0] mw(input logic [27:0] a);
        // Every word ending in 5 reads zero so the zero flag is reachable
        return (a[3:0] == 4'h5) ? 16'h0000 : (a[15:0] ^ {a[7:0], a[15:8]} ^ salt);
    endfunction : mw

    // Memory lines show the inverse when not acked, never a stale word
    assign mem_ack   = mem_req && mem_ready;
    assign mem_rdata = mem_ack ? mw(mem_addr) : ~mw(mem_addr);

    flpd_top i_flpd_top (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_mem_req(mem_req),
        .o_mem_word_addr(mem_addr), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
        .o_busy(busy)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        mem_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
    end

    task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %b seen %b", what, e, g);
        end
    endtask : chk_bit

    // Mid-cycle sampling keeps the compare clear of the edge race
    always @(negedge clk) begin
        if (busy === 1'b1) busy_cnt++;
        if (mem_req === 1'b1 && mem_ack !== 1'b1) wait_cnt++;
        if (psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0) chk_bit("stray answer", 1'b0, 1'b1);
            else begin
                cur = exp_q.pop_front();
                chk_bit("pslverr", cur.err, pslverr);
                if (cur.rd) chk_word("prdata", cur.data, prdata);
            end
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        exp_q.push_back('{~wr, e, err});
        @(posedge clk);
        penable <= 1'b1;
        @(negedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(negedge clk);
        end
        if (n == 20) chk_bit("pready", 1'b1, 1'b0);
        @(posedge clk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic set_reg(input logic [4:0] idx, input logic [31:0] v, input logic rd);
        apb(1'b1, `FLPD_OFF_REG_IDX, {27'h0, idx}, 32'h0, 1'b0);
        apb(~rd, `FLPD_OFF_REG_DATA, v, v, 1'b0);
    endtask : set_reg

    task automatic run(input int i);
        logic [4:0]  sa, sb;
        logic [3:0]  src, dst;
        logic [5:0]  w;
        logic        ea, eb, sel, fil, e;
        logic [31:0] ptr, np, v, m, iw;
        logic [7:0]  st;
        logic [47:0] win;
        int          nw, n;
        {sa, sb, ea, eb, sel, fil, src, dst} = 22'($urandom);
        ptr = $urandom;
        st  = 8'($urandom);
        slow <= (i > 3);
        case (i)
            0: {sel, sa, ptr} = {1'b0, 5'd16, 32'h0001_5560};
            1: {sel, sb, ptr} = {1'b1, 5'd0, 32'h0001_5580};
            2: {sel, sa, ptr} = {1'b0, 5'd0, 32'h0001_562f};
            3: {sel, sb, dst} = {1'b1, 5'd1, src};
            default: ;
        endcase
        w   = sel ? ((sb == 5'd0) ? 6'd32 : {1'b0, sb}) : ((sa == 5'd0) ? 6'd32 : {1'b0, sa});
        e   = sel ? eb : ea;
        np  = ptr - 32'(w);
        nw  = (int'(np[3:0]) + int'(w) + 15) / 16;
        win = {mw(np[31:4] + 28'd2), mw(np[31:4] + 28'd1), mw(np[31:4])};
        v   = 32'(win >> np[3:0]);
        if (w < 6'd32) begin
            m = (32'h1 << w) - 32'h1;
            v = (e && v[w - 6'd1]) ? (v | ~m) : (v & m);
        end
        apb(1'b1, `FLPD_OFF_CFG, {18'h0, eb, sb, 2'h0, ea, sa}, 32'h0, 1'b0);
        set_reg({fil, src}, ptr, 1'b0);
        if (dst != src) set_reg({fil, dst}, $urandom, 1'b0);
        apb(1'b1, `FLPD_OFF_STATUS, {24'h0, st}, 32'h0, 1'b0);
        busy_cnt = 0;
        wait_cnt = 0;
        iw  = {16'h0, 6'($urandom), sel, src, fil, dst};
        apb(1'b1, `FLPD_OFF_INSTR, iw, 32'h0, 1'b0);
        apb(1'b1, `FLPD_OFF_INSTR, 32'h0, 32'h0, 1'b1);
        // Two or more words keep the loader busy past this setup
        if (nw > 1) apb(1'b0, `FLPD_OFF_REG_DATA, 32'h0, 32'h0, 1'b1);
        n = 0;
        while (busy !== 1'b0 && n < 60) begin
            n++;
            @(negedge clk);
        end
        if (n == 60) chk_bit("busy", 1'b0, 1'b1);
        chk_word("busy states", 32'(2 + 2 * nw + wait_cnt), 32'(busy_cnt));
        if (dst != src) set_reg({fil, src}, np, 1'b1);
        set_reg({fil, dst}, v, 1'b1);
        apb(1'b0, `FLPD_OFF_STATUS, 0, {24'h0, v[31], st[6], v == 0, 1'b0, 4'h0}, 0);
        apb(1'b0, `FLPD_OFF_INSTR, 32'h0, iw, 1'b0);
        apb(1'b0, `FLPD_OFF_REG_IDX, 32'h0, {27'h0, fil, dst}, 1'b0);
    endtask : run

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test

    initial begin
        void'($urandom(25956));
        {psel, penable, pwrite, paddr, pwdata, slow, rst_n} = '0;
        salt = 16'($urandom);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, `FLPD_OFF_CFG, 32'h0, `FLPD_CFG_RESET, 1'b0);
        apb(1'b0, `FLPD_OFF_STATUS, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 12'h014, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'hffc, $urandom, 32'h0, 1'b1);
        for (int i = 0; i < 40; i++) run(i);
        end_of_test();
    end

    // Forty instructions need a few thousand cycles at most
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
endmodule : flpd_top_tb
